// ===== logic/ivs_pkg.sv
// package: register map, field layout, reset values and carrier types for the vector/stack/flag block
package ivs_pkg;

    // ---------------------------------------------------------------
    // register byte addresses (apb, one aligned word each)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_VECTOR_BASE   = 8'h00;
    localparam logic [7:0] ADDR_INT_CONTROL   = 8'h04;
    localparam logic [7:0] ADDR_STACK_PTRS    = 8'h08;
    localparam logic [7:0] ADDR_DATA_STACK    = 8'h0c;
    localparam logic [7:0] ADDR_COND_FLAGS    = 8'h10;
    localparam logic [7:0] ADDR_VECTOR_OUT    = 8'h14;
    localparam logic [7:0] ADDR_RX_STATUS     = 8'h18;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int RIS_MSB    = 7;
    localparam int RIS_LSB    = 6;
    localparam int MASK_MSB   = 4;
    localparam int CSP_MSB    = 7;
    localparam int CSP_LSB    = 4;
    localparam int BSP_MSB    = 3;
    localparam int FLAG_C     = 1;
    localparam int FLAG_N     = 3;
    localparam int FLAG_V     = 2;
    localparam int FLAG_Z     = 0;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_VECTOR_BASE = 8'h00;
    localparam logic [1:0] RST_RIS         = 2'h3;
    localparam logic [4:0] RST_MASK        = 5'h1f;
    localparam logic [3:0] RST_PTR         = 4'h0;
    localparam logic [3:0] RST_FLAGS       = 4'h0;

    // ---------------------------------------------------------------
    // six-bit source vector addresses
    // ---------------------------------------------------------------
    localparam logic [5:0] VEC_NMI  = 6'h1c;
    localparam logic [5:0] VEC_RX   = 6'h04;
    localparam logic [5:0] VEC_TX   = 6'h08;
    localparam logic [5:0] VEC_LTA  = 6'h0c;

    // receiver interrupt source selection codes
    typedef enum logic [1:0]
    {
        RIS_FULL_ERR  = 2'b00,
        RIS_AVAIL_ERR = 2'b01,
        RIS_UNUSED    = 2'b10,
        RIS_ACTIVE    = 2'b11
    } ivs_ris_t;

    // interrupt source selector for vector formation
    typedef enum logic [1:0]
    {
        SRC_NMI = 2'b00,
        SRC_RX  = 2'b01,
        SRC_TX  = 2'b10,
        SRC_LTA = 2'b11
    } ivs_src_t;

    // result flags of one alu operation
    typedef struct packed
    {
        logic arith;   // arithmetic instruction finished
        logic logic_op;// logical or shift instruction finished
        logic shift;   // operation was a shift or rotate
        logic carry;   // carry/borrow or last bit shifted out
        logic neg;     // result negative
        logic ovf;     // arithmetic overflow
        logic zero;    // result zero
    } ivs_alu_t;

    // receiver status levels and events
    typedef struct packed
    {
        logic fifo_full;  // receive fifo full level
        logic word_valid; // valid word arrived (pulse)
        logic word_read;  // word read by cpu (pulse)
        logic start_seq;  // valid starting sequence (pulse)
        logic end_msg;    // end of message (pulse)
        logic fault;      // receiver error detected (pulse)
    } ivs_rx_t;

endpackage

// ===== logic/ivs_core.sv
// module: vector base, receiver interrupt select, stacks and condition flags with apb access
module ivs_core
    import ivs_pkg::*;
#(
    parameter int STACK_DEPTH = 16
)
(
    input  wire logic        SYS_CLK,          // cpu clock, 125 mhz
    input  wire logic        RST_B,            // synchronous reset, active low
    input  wire logic        PSEL,             // apb select
    input  wire logic        PENABLE,          // apb access phase
    input  wire logic        PWRITE,           // apb write
    input  wire logic [7:0]  PADDR,            // apb byte address
    input  wire logic [31:0] PWDATA,           // apb write data
    output logic      [31:0] PRDATA,           // apb read data
    output logic             PREADY,           // apb ready
    output logic             PSLVERR,          // apb error on unmapped address
    input  wire ivs_alu_t    ALU_RESULT,       // alu flag results of one instruction
    input  wire ivs_rx_t     RX_EVENTS,        // receiver levels and event pulses
    input  wire ivs_src_t    IRQ_SOURCE,       // source whose vector is formed
    output logic      [15:0] IRQ_VECTOR,       // formed vector address
    output logic             RX_IRQ_REQ,       // selected receiver interrupt request
    output logic      [4:0]  IRQ_MASK,         // mask bits of control register
    output logic      [3:0]  COND_FLAGS_OUT    // n, v, c, z as in register
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed
    {
        logic [7:0]  vector_base;
        logic [1:0]  rx_irq_source_sel;
        logic [4:0]  irq_mask;
        logic [3:0]  call_stack_ptr;
        logic [3:0]  byte_stack_ptr;
        logic [STACK_DEPTH-1:0][7:0] byte_stack;
        logic [3:0]  flags;
        logic        rx_word_ready;
        logic        rx_in_message;
        logic        rx_fault;
        logic [31:0] rdata;
        logic [15:0] vector;
        logic        rx_irq;
        logic        rd_done;      // read data captured, answer in this access cycle
    } ivs_state_t;

    ivs_state_t state_r;
    ivs_state_t state_nxt;

    logic       wr_en;
    logic       rd_en;
    logic       mapped;
    logic [5:0] src_addr;
    logic [3:0] bsp_dec;

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    // reads take one wait state so that registered read data stands at the ready edge;
    // capture happens once per read, so a pop steps the pointer only once
    assign wr_en   = PSEL && PENABLE && PWRITE && mapped;
    assign rd_en   = PSEL && PENABLE && !PWRITE && mapped && !state_r.rd_done;
    assign PREADY  = PSEL && PENABLE && (PWRITE || !mapped || state_r.rd_done);
    assign PSLVERR = PSEL && PENABLE && !mapped;

    // address decode, vector and status registers are read only
    always_comb
    begin
        unique case (PADDR)
            ADDR_VECTOR_BASE, ADDR_INT_CONTROL, ADDR_STACK_PTRS, ADDR_DATA_STACK,
            ADDR_COND_FLAGS, ADDR_VECTOR_OUT, ADDR_RX_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // six-bit source vector address per source
    always_comb
    begin
        unique case (IRQ_SOURCE)
            SRC_NMI: src_addr = VEC_NMI;
            SRC_RX:  src_addr = VEC_RX;
            SRC_TX:  src_addr = VEC_TX;
            SRC_LTA: src_addr = VEC_LTA;
        endcase
    end

    assign bsp_dec = state_r.byte_stack_ptr - 4'h1;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;

        // receiver status flags, set wins over clear
        if (RX_EVENTS.fault || RX_EVENTS.word_read)
        begin
            state_nxt.rx_word_ready = 1'b0;
        end
        if (RX_EVENTS.word_valid)
        begin
            state_nxt.rx_word_ready = 1'b1;
        end
        if (RX_EVENTS.fault || RX_EVENTS.end_msg)
        begin
            state_nxt.rx_in_message = 1'b0;
        end
        if (RX_EVENTS.start_seq)
        begin
            state_nxt.rx_in_message = 1'b1;
        end
        if (rd_en && PADDR == ADDR_RX_STATUS)
        begin
            state_nxt.rx_fault = 1'b0;                 // read clears the error latch
        end
        if (RX_EVENTS.fault)
        begin
            state_nxt.rx_fault = 1'b1;
        end

        // condition flags from alu; other instructions leave them
        if (ALU_RESULT.arith || ALU_RESULT.logic_op)
        begin
            state_nxt.flags[FLAG_N] = ALU_RESULT.neg;
            state_nxt.flags[FLAG_Z] = ALU_RESULT.zero;
        end
        if (ALU_RESULT.arith)
        begin
            state_nxt.flags[FLAG_V] = ALU_RESULT.ovf;
        end
        if (ALU_RESULT.arith || ALU_RESULT.shift)
        begin
            state_nxt.flags[FLAG_C] = ALU_RESULT.carry;
        end

        // register writes
        if (wr_en)
        begin
            unique case (PADDR)
                ADDR_VECTOR_BASE:
                    state_nxt.vector_base = PWDATA[7:0];
                ADDR_INT_CONTROL:
                begin
                    state_nxt.rx_irq_source_sel = PWDATA[RIS_MSB:RIS_LSB];
                    state_nxt.irq_mask          = PWDATA[MASK_MSB:0];
                end
                ADDR_STACK_PTRS:
                begin
                    state_nxt.call_stack_ptr = PWDATA[CSP_MSB:CSP_LSB];
                    state_nxt.byte_stack_ptr = PWDATA[BSP_MSB:0];
                end
                ADDR_DATA_STACK:
                begin
                    // push: store then advance, wraps modulo sixteen
                    state_nxt.byte_stack[state_r.byte_stack_ptr] = PWDATA[7:0];
                    state_nxt.byte_stack_ptr = state_r.byte_stack_ptr + 4'h1;
                end
                ADDR_COND_FLAGS:
                    state_nxt.flags = PWDATA[3:0];
                default:
                begin
                end
            endcase
        end

        // read data, captured at the first access edge, shown with ready at the next
        state_nxt.rd_done = rd_en;
        state_nxt.rdata = 32'h0;
        if (rd_en)
        begin
            unique case (PADDR)
                ADDR_VECTOR_BASE: state_nxt.rdata = {24'h0, state_r.vector_base};
                ADDR_INT_CONTROL: state_nxt.rdata = {24'h0, state_r.rx_irq_source_sel, 1'b0, state_r.irq_mask};
                ADDR_STACK_PTRS:  state_nxt.rdata = {24'h0, state_r.call_stack_ptr, state_r.byte_stack_ptr};
                ADDR_DATA_STACK:
                begin
                    // pop: step back then read
                    state_nxt.rdata          = {24'h0, state_r.byte_stack[bsp_dec]};
                    state_nxt.byte_stack_ptr = bsp_dec;
                end
                ADDR_COND_FLAGS:  state_nxt.rdata = {28'h0, state_r.flags};
                ADDR_VECTOR_OUT:  state_nxt.rdata = {16'h0, state_r.vector};
                ADDR_RX_STATUS:   state_nxt.rdata = {28'h0, state_r.rx_fault, state_r.rx_in_message,
                                                     state_r.rx_word_ready, RX_EVENTS.fifo_full};
                default:
                begin
                end
            endcase
        end

        // vector formation
        state_nxt.vector = {state_r.vector_base, 2'b00, src_addr};

        // receiver interrupt source selection
        unique case (ivs_ris_t'(state_r.rx_irq_source_sel))
            RIS_FULL_ERR:  state_nxt.rx_irq = RX_EVENTS.fifo_full || state_r.rx_fault;
            RIS_AVAIL_ERR: state_nxt.rx_irq = state_r.rx_word_ready || state_r.rx_fault;
            RIS_UNUSED:    state_nxt.rx_irq = 1'b0;
            RIS_ACTIVE:    state_nxt.rx_irq = state_r.rx_in_message;
        endcase

        // synchronous reset; stack contents are left undefined
        if (!RST_B)
        begin
            state_nxt.vector_base       = RST_VECTOR_BASE;
            state_nxt.rx_irq_source_sel = RST_RIS;
            state_nxt.irq_mask          = RST_MASK;
            state_nxt.call_stack_ptr    = RST_PTR;
            state_nxt.byte_stack_ptr    = RST_PTR;
            state_nxt.flags             = RST_FLAGS;
            state_nxt.rx_word_ready     = 1'b0;
            state_nxt.rx_in_message     = 1'b0;
            state_nxt.rx_fault          = 1'b0;
            state_nxt.rdata             = 32'h0;
            state_nxt.vector            = {RST_VECTOR_BASE, 2'b00, VEC_NMI};
            state_nxt.rx_irq            = 1'b0;
            state_nxt.rd_done           = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge SYS_CLK)
    begin
        state_r <= state_nxt;
    end

    // outputs
    assign PRDATA         = state_r.rdata;
    assign IRQ_VECTOR     = state_r.vector;
    assign RX_IRQ_REQ     = state_r.rx_irq;
    assign IRQ_MASK       = state_r.irq_mask;
    assign COND_FLAGS_OUT = state_r.flags;

endmodule

// ===== verification/ivs_chk.sv
// checker: port assertions for the vector, stack and flag block
module ivs_chk
    import ivs_pkg::*;
(
    input wire logic        SYS_CLK,       // cpu clock
    input wire logic        RST_B,         // sync reset, low
    input wire logic        PSEL,          // apb select
    input wire logic        PENABLE,       // apb access
    input wire logic        PWRITE,        // apb write
    input wire logic [7:0]  PADDR,         // apb address
    input wire logic [31:0] PWDATA,        // apb write data
    input wire logic [31:0] PRDATA,        // apb read data
    input wire ivs_alu_t    ALU_RESULT,    // alu pulse
    input wire ivs_src_t    IRQ_SOURCE,    // vector source
    input wire logic [15:0] IRQ_VECTOR,    // formed vector
    input wire logic [4:0]  IRQ_MASK,      // mask bits
    input wire logic [3:0]  COND_FLAGS_OUT // n v c z
);
    // ----------------
    // clocking and helpers
    // ----------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    logic wr_flg; // software write to the flags wins over the alu
    assign wr_flg = PSEL && PENABLE && PWRITE && PADDR == ADDR_COND_FLAGS;

    // ----------------
    // assertions
    // ----------------
    a_reset_vals: assert property (!$past(RST_B) |-> IRQ_VECTOR == 16'h001c && IRQ_MASK == 5'h1f
        && COND_FLAGS_OUT == 4'h0 && PRDATA == 32'h0) else $error("bad value after reset");
    a_vec_nmi_rx: assert property ($past(RST_B) |-> ($past(IRQ_SOURCE) != SRC_NMI || IRQ_VECTOR[7:0] == 8'h1c)
        && ($past(IRQ_SOURCE) != SRC_RX || IRQ_VECTOR[7:0] == 8'h04)) else $error("nmi or rx vector wrong");
    a_vec_tx_lta: assert property ($past(RST_B) |-> ($past(IRQ_SOURCE) != SRC_TX || IRQ_VECTOR[7:0] == 8'h08)
        && ($past(IRQ_SOURCE) != SRC_LTA || IRQ_VECTOR[7:0] == 8'h0c)) else $error("tx or lta vector wrong");
    a_vec_base: assert property (PSEL && PENABLE && PWRITE && PADDR == ADDR_VECTOR_BASE |=> ##1
        IRQ_VECTOR[15:8] == $past(PWDATA[7:0], 2)) else $error("vector high byte wrong");
    a_flags_keep: assert property (!ALU_RESULT.arith && !ALU_RESULT.logic_op && !ALU_RESULT.shift
        && !wr_flg |=> $stable(COND_FLAGS_OUT)) else $error("flags moved without cause");
    a_arith_flags: assert property (ALU_RESULT.arith && !wr_flg |=> COND_FLAGS_OUT == {$past(ALU_RESULT.neg),
        $past(ALU_RESULT.ovf), $past(ALU_RESULT.carry), $past(ALU_RESULT.zero)}) else $error("arith flags wrong");
    a_logic_nz: assert property (ALU_RESULT.logic_op && !ALU_RESULT.arith && !wr_flg |=>
        COND_FLAGS_OUT[3] == $past(ALU_RESULT.neg) && COND_FLAGS_OUT[0] == $past(ALU_RESULT.zero)
        && $stable(COND_FLAGS_OUT[2])) else $error("logic flags wrong");
    a_shift_carry: assert property (ALU_RESULT.shift && !ALU_RESULT.arith && !wr_flg |=>
        COND_FLAGS_OUT[1] == $past(ALU_RESULT.carry)) else $error("shift carry wrong");

    // main scenarios
    c_arith: cover property (ALU_RESULT.arith);
    c_flag_wr: cover property (wr_flg);
    c_pop: cover property (PSEL && PENABLE && !PWRITE && PADDR == ADDR_DATA_STACK);
endmodule

bind ivs_core ivs_chk u_chk (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .ALU_RESULT(ALU_RESULT),
    .IRQ_SOURCE(IRQ_SOURCE), .IRQ_VECTOR(IRQ_VECTOR), .IRQ_MASK(IRQ_MASK), .COND_FLAGS_OUT(COND_FLAGS_OUT));

// ===== verification/testbench.sv
// testbench: apb, vector, stack, flag and receiver checks against a bench model
module testbench
    import ivs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        SYS_CLK, RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, RX_IRQ_REQ;
    logic [7:0]  PADDR, vb, pv;
    logic [31:0] PWDATA, PRDATA, q;
    logic [15:0] IRQ_VECTOR;
    logic [4:0]  IRQ_MASK;
    logic [3:0]  COND_FLAGS_OUT, fl;
    ivs_alu_t    ALU_RESULT;
    ivs_rx_t     RX_EVENTS;
    ivs_src_t    IRQ_SOURCE;
    logic [7:0]  bq[$];
    logic        ful, rdy, act, flt, req, err;
    int          fail_count, samples_checked;
    logic [5:0]  vt[4] = '{6'h1c, 6'h04, 6'h08, 6'h0c};

    ivs_core dut (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .ALU_RESULT(ALU_RESULT), .RX_EVENTS(RX_EVENTS), .IRQ_SOURCE(IRQ_SOURCE), .IRQ_VECTOR(IRQ_VECTOR),
        .RX_IRQ_REQ(RX_IRQ_REQ), .IRQ_MASK(IRQ_MASK), .COND_FLAGS_OUT(COND_FLAGS_OUT));

    // 125 mhz clock
    initial
    begin
        SYS_CLK = 1'b0;
        forever #4 SYS_CLK = ~SYS_CLK;
    end

    // ----------------
    // shared tasks
    // ----------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // one apb transfer; error and read data are taken at the ready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        n = 0;
        do
        begin
            @(posedge SYS_CLK);
            n++;
        end
        while (PREADY !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            fail_count++;
            results();
        end
        err = PSLVERR;
        q = PRDATA;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge SYS_CLK);
    endtask

    // expected receiver request for a select code
    function automatic logic rxf(input logic [1:0] s);
        return s == 2'b00 ? (ful | flt) : s == 2'b01 ? (rdy | flt) : s == 2'b11 ? act : 1'b0;
    endfunction

    // ----------------
    // main sequence
    // ----------------
    initial
    begin
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA, ALU_RESULT, RX_EVENTS} = '0;
        IRQ_SOURCE = SRC_NMI;
        RST_B = 1'b0;
        {ful, rdy, act, flt, fl, fail_count, samples_checked} = '0;
        void'($urandom(42515));
        repeat (10) @(posedge SYS_CLK);
        RST_B <= 1'b1;
        @(posedge SYS_CLK);
        // reset values and an unmapped place
        apb(1'b0, ADDR_VECTOR_BASE, 0); chk(q, 32'h0);
        apb(1'b0, ADDR_INT_CONTROL, 0); chk(q, 32'hdf);
        apb(1'b0, ADDR_STACK_PTRS, 0); chk(q, 32'h0);
        apb(1'b0, ADDR_COND_FLAGS, 0); chk(q, 32'h0);
        apb(1'b0, 8'h40, 0); chk(err, 1'b1);
        chk(q, 32'h0);
        // vector formed from base and every source
        vb = 8'($urandom);
        apb(1'b1, ADDR_VECTOR_BASE, {24'($urandom), vb});
        apb(1'b1, ADDR_VECTOR_OUT, 32'hffff);
        apb(1'b0, ADDR_VECTOR_BASE, 0); chk(q, vb);
        for (int s = 0; s < 4; s++)
        begin
            IRQ_SOURCE <= ivs_src_t'(s);
            repeat (2) @(posedge SYS_CLK);
            chk(IRQ_VECTOR, {vb, 2'b00, vt[s]});
        end
        // pointers, then a full lap of pushes and pops
        pv = 8'($urandom);
        apb(1'b1, ADDR_STACK_PTRS, pv);
        apb(1'b0, ADDR_STACK_PTRS, 0); chk(q, pv);
        repeat (16)
        begin
            vb = 8'($urandom);
            bq.push_back(vb);
            apb(1'b1, ADDR_DATA_STACK, vb);
        end
        apb(1'b0, ADDR_STACK_PTRS, 0); chk(q, pv);
        repeat (16)
        begin
            apb(1'b0, ADDR_DATA_STACK, 0); chk(q, bq.pop_back());
        end
        // random alu results against the flag model
        for (int i = 0; i < 80; i++)
        begin
            @(posedge SYS_CLK);
            chk(COND_FLAGS_OUT, fl);
            if (ALU_RESULT.arith)
                fl = {ALU_RESULT.neg, ALU_RESULT.ovf, ALU_RESULT.carry, ALU_RESULT.zero};
            else
            begin
                if (ALU_RESULT.logic_op)
                    {fl[3], fl[0]} = {ALU_RESULT.neg, ALU_RESULT.zero};
                if (ALU_RESULT.shift)
                    fl[1] = ALU_RESULT.carry;
            end
            ALU_RESULT <= (i < 79 && $urandom % 3 != 0) ? ivs_alu_t'(7'($urandom)) : '0;
        end
        pv = 8'($urandom % 16);
        apb(1'b1, ADDR_COND_FLAGS, pv);
        apb(1'b0, ADDR_COND_FLAGS, 0); chk(q, pv);
        // every receiver select code with random events
        for (int s = 0; s < 4; s++)
        begin
            vb = {s[1:0], 6'($urandom)};
            apb(1'b1, ADDR_INT_CONTROL, vb); chk(IRQ_MASK, vb[4:0]);
            apb(1'b0, ADDR_INT_CONTROL, 0); chk(q, vb & 8'hdf);
            req = rxf(vb[7:6]);
            for (int i = 0; i <= 24; i++)
            begin
                @(posedge SYS_CLK);
                chk(RX_IRQ_REQ, req);
                ful = RX_EVENTS.fifo_full;
                req = rxf(vb[7:6]);
                rdy = RX_EVENTS.word_valid | (rdy & !RX_EVENTS.word_read & !RX_EVENTS.fault);
                act = RX_EVENTS.start_seq | (act & !RX_EVENTS.end_msg & !RX_EVENTS.fault);
                flt |= RX_EVENTS.fault;
                RX_EVENTS <= (i < 24) ? ivs_rx_t'(6'($urandom) & ($urandom % 6 ? 6'h3e : 6'h3f)) : '0;
            end
            apb(1'b0, ADDR_RX_STATUS, 0); chk(q, {flt, act, rdy, 1'b0});
            flt = 1'b0;
            ful = 1'b0;
        end
        results();
    end
endmodule
